/* cmp_consts.svh */
// register offsets, field positions, reset values and timing counts of the comparator control
`ifndef CMP_CONSTS_SVH
`define CMP_CONSTS_SVH

`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define ENABLE_POS 15
`define PIN_DRIVE_POS 14
`define INVERT_POS 13
`define RESULT_POS 8
`define EDGE_HI_POS 7
`define EDGE_LO_POS 6
`define POS_SEL_POS 4
`define NEG_HI_POS 1
`define NEG_LO_POS 0
`define CTRL_WRITE_MASK 32'h0000E0D3
`define CTRL_RESET 32'h000000C3
`define SYNC_STAGES 2

`endif

/* cmp_pkg.sv */
// types shared by the comparator control files
package cmp_pkg;

typedef enum logic [1:0] {
   edge_off_type = 2'h0,
   edge_rise_type = 2'h1,
   edge_fall_type = 2'h2,
   edge_both_type = 2'h3
} edge_sel_type;

typedef enum logic [1:0] {
   neg_own_neg_type = 2'h0,
   neg_own_pos_type = 2'h1,
   neg_other_pos_type = 2'h2,
   neg_bandgap_type = 2'h3
} neg_sel_type;

typedef struct packed {
   logic enable;
   logic pin_drive_enable;
   logic result_invert;
   edge_sel_type irq_edge_select;
   logic pos_input_select;
   neg_sel_type neg_input_select;
} ctrl_type;

typedef struct packed {
   logic [11:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
} apb_req_type;

typedef struct packed {
   logic pready;
   logic pslverr;
   logic [31:0] prdata;
} apb_rsp_type;

typedef struct packed {
   logic comp_enable;
   logic pos_route_ref;
   neg_sel_type neg_route;
} analog_ctl_type;

endpackage

/* cmp_edge_detect.sv */
// synchroniser and edge event detector for the comparator result
`timescale 1ns/1ps
`default_nettype none
`include "cmp_consts.svh"

module cmp_edge_detect
   import cmp_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic raw_result,
   input wire logic invert,
   input wire logic enable,
   input wire cmp_pkg::edge_sel_type edge_sel,
   output logic result,
   output logic event_pulse
);

   typedef struct packed {
      logic [`SYNC_STAGES-1:0] sync;
      logic prev;
      logic valid;
      logic pulse;
   } edge_state_type;

   edge_state_type state;
   edge_state_type next_state;
   logic level;
   logic rise;
   logic fall;

   always_comb
   begin
      next_state = state;
      next_state.sync = {state.sync[`SYNC_STAGES-2:0], raw_result};
      level = state.sync[`SYNC_STAGES-1] ^ invert;
      rise = state.valid && level && !state.prev;
      fall = state.valid && !level && state.prev;
      next_state.prev = level;
      next_state.valid = enable;
      unique case (edge_sel)
         edge_off_type: next_state.pulse = 1'b0;
         edge_rise_type: next_state.pulse = rise;
         edge_fall_type: next_state.pulse = fall;
         edge_both_type: next_state.pulse = rise | fall;
      endcase
      if (!enable)
      begin
         next_state.pulse = 1'b0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign result = state.prev;
   assign event_pulse = state.pulse;

endmodule

`default_nettype wire

/* cmp_control.sv */
// comparator control register, apb slave and output gating
//
// Operation
// - clearing enable powers down, other bits kept
// - pin drive enable drives result pin
// - invert bit inverts presented result
// - inversion also feeds edge detector
// - result bit reads presented result level
// - edge select field chooses interrupt edges
// - positive select routes reference or pin
// - negative select chooses inverting input
// - unused bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
`include "cmp_consts.svh"

module cmp_control
   import cmp_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire cmp_pkg::apb_req_type apb_req,
   output cmp_pkg::apb_rsp_type apb_rsp,
   input wire logic raw_result,
   output cmp_pkg::analog_ctl_type analog_ctl,
   output logic result_pin_out,
   output logic result_pin_oe,
   output logic irq_event
);
   import cmp_pkg::*;

   typedef struct packed {
      ctrl_type ctrl;
      logic [31:0] prdata;
      logic pslverr;
      logic pin_out;
      logic pin_oe;
      analog_ctl_type analog;
   } top_state_type;

   top_state_type state;
   top_state_type next_state;
   logic result;
   logic event_pulse;
   logic setup;
   logic [31:0] ctrl_word;
   logic [31:0] merged;

   // ***********************************
   // register word packing
   // ***********************************
   function automatic logic [31:0] pack_ctrl(input ctrl_type c, input logic res);
      logic [31:0] w;
      w = 32'h00000000;
      w[`ENABLE_POS] = c.enable;
      w[`PIN_DRIVE_POS] = c.pin_drive_enable;
      w[`INVERT_POS] = c.result_invert;
      w[`RESULT_POS] = res;
      w[`EDGE_HI_POS:`EDGE_LO_POS] = c.irq_edge_select;
      w[`POS_SEL_POS] = c.pos_input_select;
      w[`NEG_HI_POS:`NEG_LO_POS] = c.neg_input_select;
      return w;
   endfunction

   function automatic ctrl_type unpack_ctrl(input logic [31:0] w);
      ctrl_type c;
      c.enable = w[`ENABLE_POS];
      c.pin_drive_enable = w[`PIN_DRIVE_POS];
      c.result_invert = w[`INVERT_POS];
      c.irq_edge_select = edge_sel_type'(w[`EDGE_HI_POS:`EDGE_LO_POS]);
      c.pos_input_select = w[`POS_SEL_POS];
      c.neg_input_select = neg_sel_type'(w[`NEG_HI_POS:`NEG_LO_POS]);
      return c;
   endfunction

   function automatic logic [31:0] strobe_mask(input logic [3:0] s);
      logic [31:0] m;
      m = 32'h00000000;
      for (int i = 0; i < 4; i++)
      begin
         m[i*8 +: 8] = {8{s[i]}};
      end
      return m;
   endfunction

   cmp_edge_detect u_edge (
      .core_clk(core_clk),
      .srst(srst),
      .raw_result(raw_result),
      .invert(state.ctrl.result_invert),
      .enable(state.ctrl.enable),
      .edge_sel(state.ctrl.irq_edge_select),
      .result(result),
      .event_pulse(event_pulse)
   );

   // ***********************************
   // next state
   // ***********************************
   always_comb
   begin
      next_state = state;
      setup = apb_req.psel && !apb_req.penable;
      ctrl_word = pack_ctrl(state.ctrl, result);
      merged = (ctrl_word & ~(strobe_mask(apb_req.pstrb) & `CTRL_WRITE_MASK))
         | (apb_req.pwdata & strobe_mask(apb_req.pstrb) & `CTRL_WRITE_MASK);
      if (apb_req.psel && apb_req.penable && apb_req.pwrite
         && apb_req.paddr == `CTRL_OFFSET)
      begin
         next_state.ctrl = unpack_ctrl(merged);
      end
      if (setup)
      begin
         next_state.pslverr = 1'b0;
         next_state.prdata = 32'h00000000;
         unique case (apb_req.paddr)
            `CTRL_OFFSET:
            begin
               next_state.prdata = ctrl_word;
            end
            `STATUS_OFFSET:
            begin
               next_state.prdata = 32'h00000000;
               next_state.prdata[`RESULT_POS] = result;
               next_state.prdata[0] = event_pulse;
               if (apb_req.pwrite)
               begin
                  next_state.pslverr = 1'b1;
               end
            end
            default:
            begin
               next_state.pslverr = 1'b1;
            end
         endcase
      end
      next_state.pin_out = result && state.ctrl.enable;
      next_state.pin_oe = state.ctrl.pin_drive_enable;
      next_state.analog.comp_enable = state.ctrl.enable;
      next_state.analog.pos_route_ref = state.ctrl.pos_input_select;
      next_state.analog.neg_route = state.ctrl.neg_input_select;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state <= '0;
         state.ctrl <= unpack_ctrl(`CTRL_RESET);
         state.analog.neg_route <= neg_bandgap_type;
      end
      else
      begin
         state <= next_state;
      end
   end

   // one driver for the whole response: ready always high, no wait states
   assign apb_rsp = {1'b1, state.pslverr, state.prdata};
   assign analog_ctl = state.analog;
   assign result_pin_out = state.pin_out;
   assign result_pin_oe = state.pin_oe;
   assign irq_event = event_pulse;

endmodule

`default_nettype wire

/* cmp_ctl_assertions.sv */
// port checker of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module cmp_ctl_assertions
   import cmp_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire cmp_pkg::apb_req_type apb_req,
   input wire cmp_pkg::apb_rsp_type apb_rsp,
   input wire logic raw_result,
   input wire cmp_pkg::analog_ctl_type analog_ctl,
   input wire logic result_pin_out,
   input wire logic result_pin_oe,
   input wire logic irq_event
);
   // ****
   // port relations
   // ****
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (srst);
   sequence s_wr;
      apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == 12'h000
         && apb_req.pstrb == 4'hF;
   endsequence
   sequence s_off;
      !analog_ctl.comp_enable ##1 !analog_ctl.comp_enable;
   endsequence
   property p_en;
      s_wr |-> ##2 analog_ctl.comp_enable == $past(apb_req.pwdata[15], 2);
   endproperty
   property p_oe;
      s_wr |-> ##2 result_pin_oe == $past(apb_req.pwdata[14], 2);
   endproperty
   property p_pos;
      s_wr |-> ##2 analog_ctl.pos_route_ref == $past(apb_req.pwdata[4], 2);
   endproperty
   property p_neg;
      s_wr |-> ##2 analog_ctl.neg_route == $past(apb_req.pwdata[1:0], 2);
   endproperty
   property p_off;
      s_off |-> !result_pin_out;
   endproperty
   property p_quiet;
      s_off |-> !irq_event;
   endproperty
   property p_pulse;
      irq_event |=> !irq_event;
   endproperty
   property p_rsv;
      apb_req.psel && apb_req.penable && !apb_req.pwrite
         |-> apb_rsp.prdata[31:16] == 16'h0000 && apb_rsp.prdata[12:9] == 4'h0;
   endproperty
   a_en: assert property (p_en) else $error("enable not from write");
   a_oe: assert property (p_oe) else $error("pin drive not from write");
   a_pos: assert property (p_pos) else $error("positive route wrong");
   a_neg: assert property (p_neg) else $error("negative route wrong");
   a_off: assert property (p_off) else $error("pin driven while off");
   a_quiet: assert property (p_quiet) else $error("event while off");
   a_pulse: assert property (p_pulse) else $error("event longer than one cycle");
   a_rsv: assert property (p_rsv) else $error("unused bits not zero");
endmodule

bind cmp_control cmp_ctl_assertions chk_u (
   .core_clk(core_clk),
   .srst(srst),
   .apb_req(apb_req),
   .apb_rsp(apb_rsp),
   .raw_result(raw_result),
   .analog_ctl(analog_ctl),
   .result_pin_out(result_pin_out),
   .result_pin_oe(result_pin_oe),
   .irq_event(irq_event)
);
`default_nettype wire

/* cmp_analog_model.sv */
// behavioural analog comparator core behind the control block
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model
   import cmp_pkg::*;
(
   input wire cmp_pkg::analog_ctl_type analog_ctl,
   input wire logic [7:0] levels,
   output logic raw_result
);
   // ****
   // output keeps running when powered down; the block gates the pin
   // ****
   // routed pair decides
   assign raw_result = levels[{analog_ctl.pos_route_ref, analog_ctl.neg_route}];
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cmp_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] levels = 8'h00;
   logic raw_result;
   apb_req_type req = '0;
   apb_rsp_type rsp;
   analog_ctl_type actl;
   logic pin_out;
   logic pin_oe;
   logic irq_event;
   logic [31:0] q;
   logic e;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_irq = 0;
   int b;
   // ****
   // harness
   // ****
   always #2.5 core_clk = ~core_clk;
   cmp_control dut_u (.core_clk(core_clk), .srst(srst), .apb_req(req), .apb_rsp(rsp),
      .raw_result(raw_result), .analog_ctl(actl), .result_pin_out(pin_out),
      .result_pin_oe(pin_oe), .irq_event(irq_event));
   cmp_analog_model model_u (.analog_ctl(actl), .levels(levels), .raw_result(raw_result));
   task automatic print_verdict();
      if (bad_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (irq_event === 1'b1)
         n_irq <= n_irq + 1;
      if (cyc == 5000)
      begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      req <= '{a, 1'b1, 1'b0, w, d, 4'hF};
      @(posedge core_clk);
      req.penable <= 1'b1;
      do
         @(posedge core_clk);
      while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic cfg(input logic [31:0] d);
      xfer(1'b1, 12'h000, d);
      repeat (6) @(posedge core_clk);
   endtask
   // ****
   // tests
   // ****
   initial
   begin
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      xfer(1'b0, 12'h000, 32'h0);
      chk(q, 32'h000000C3);
      xfer(1'b1, 12'h000, 32'hFFFFFFFF);
      xfer(1'b0, 12'h000, 32'h0);
      chk(q, 32'h0000E1D3);
      xfer(1'b0, 12'h008, 32'h0);
      chk({e, q[30:0]}, 32'h80000000);
      levels <= 8'hA5;
      for (int i = 0; i < 16; i++)
      begin
         cfg({16'h0, 2'b11, i[3], 8'h0, i[2], 2'b00, i[1:0]});
         xfer(1'b0, 12'h004, 32'h0);
         chk(q, {23'h0, levels[i[2:0]] ^ i[3], 8'h00});
         chk({30'h0, pin_oe, pin_out}, {30'h0, 1'b1, levels[i[2:0]] ^ i[3]});
      end
      for (int j = 0; j < 8; j++)
      begin
         levels <= 8'h00;
         cfg({16'h0, 2'b10, j[2], 5'h0, j[1:0], 6'h0});
         chk({31'h0, pin_oe}, 32'h0);
         b = n_irq;
         levels <= 8'h01;
         repeat (8) @(posedge core_clk);
         chk(n_irq - b, j[2] ? j[1] : j[0]);
         levels <= 8'h00;
         repeat (8) @(posedge core_clk);
         chk(n_irq - b, int'(j[1]) + int'(j[0]));
      end
      cfg(32'h0000C0C0);
      cfg(32'h000040C0);
      b = n_irq;
      levels <= 8'h01;
      repeat (8) @(posedge core_clk);
      chk(n_irq - b, 32'h0);
      chk({31'h0, pin_out}, 32'h0);
      xfer(1'b0, 12'h000, 32'h0);
      chk(q, 32'h000041C0);
      print_verdict();
   end
endmodule
`default_nettype wire
